// ===== logic/gpio_pkg.sv
// constants and layouts shared by the bidirectional port design
// Summary of operation
// - eight-bit port, each bit can be input or output.
// - direction bit one turns the pin driver off, pin is input.
// - direction bit zero drives the pin from the output latch.
// - pin-level register reads pin levels; writing it loads the output latch.
// - output latch readable on its own, returning latched value for read-modify-write.
// - an enabled sharing peripheral takes the pin away from general I/O.
// - bit 4 shares timer clock input and comparator output; Schmitt input there.
// - bits 6 and 7 are oscillator pins or I/O by oscillator configuration.
// - bits 6 and 7 read zero in pin, direction, latch when not port pins.
// - analog configuration selects analog or digital for bits 3..0 and 5.
// - after reset bits 5, 3..0 analog reading zero; bit 4 digital input.
// - comparators can claim bits 0..5; software turns them off for digital inputs.
// - direction bits keep driver control on analog pins; software keeps them set.
// - change on second port bits 7..4 sets flag; enable gates, priority selects.
package gpio_pkg;
  localparam int PORT_W = 8;
  localparam int CHG_W = 4;
  localparam int ADDR_W = 3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_PIN_LEVEL = 3'h0;
  localparam logic [2:0] OFS_LATCH = 3'h1;
  localparam logic [2:0] OFS_DIRECTION = 3'h2;
  localparam logic [2:0] OFS_ANALOG_CFG = 3'h3;
  localparam logic [2:0] OFS_COMP_CTRL = 3'h4;
  localparam logic [2:0] OFS_INT_STATUS = 3'h5;
  localparam logic [2:0] OFS_INT_MASK = 3'h6;
  localparam logic [2:0] OFS_INT_PRIO = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // analog config: bits 3..0 map to pins 3..0, bit 4 maps to pin 5
  localparam int ACFG_PIN5_BIT = 4;
  localparam int COMP_IN_BIT = 0;
  localparam int COMP1_OUT_BIT = 1;
  localparam int COMP2_OUT_BIT = 2;
  localparam int CHG_FLAG_BIT = 0;
  localparam int TIMER_PIN = 4;
  localparam int COMP2_PIN = 5;
  localparam int OSC_PIN_LO = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [4:0] RST_ANALOG_CFG = 5'h1F;
  localparam logic [2:0] RST_COMP_CTRL = 3'h0;
endpackage

// ===== logic/gpio_port.sv
// eight-bit bidirectional port with change interrupt on second port
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module gpio_port
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [gpio_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic [gpio_pkg::PORT_W-1:0] pin_in,
  output logic [gpio_pkg::PORT_W-1:0] pin_out,
  output logic [gpio_pkg::PORT_W-1:0] pin_oe_n,
  input wire logic [gpio_pkg::CHG_W-1:0] second_port_in,
  input wire logic osc_pins_as_io,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  output logic timer_clock_input,
  output logic [gpio_pkg::CHG_W-1:0] second_port_level,
  output logic irq,
  output logic irq_high_prio
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  localparam int SW = PORT_W + CHG_W;

  sync_if #(.W(SW)) sif ();

  assign sif.raw = {second_port_in, pin_in};

  input_sync #(.W(SW)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .ce(ce),
    .sif(sif)
  );

  logic [PORT_W-1:0] pin_sync;
  logic [CHG_W-1:0] chg_sync;
  assign pin_sync = sif.synced[PORT_W-1:0];
  assign chg_sync = sif.synced[SW-1:PORT_W];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] output_latch_reg_a_r, output_latch_reg_a_nxt;
  logic [7:0] direction_reg_a_r, direction_reg_a_nxt;
  logic [4:0] analog_config_control_r, analog_config_control_nxt;
  logic [2:0] comparator_control_r, comparator_control_nxt;
  logic port_change_flag_r, port_change_flag_nxt;
  logic port_change_enable_r, port_change_enable_nxt;
  logic port_change_priority_r, port_change_priority_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] pin_out_r, pin_out_nxt;
  logic [7:0] pin_oe_n_r, pin_oe_n_nxt;

  // expand the five-bit analog selection onto port bit positions
  function automatic logic [7:0] analog_pins(input logic [4:0] cfg);
    analog_pins = {2'b00, cfg[ACFG_PIN5_BIT], 1'b0, cfg[3:0]};
  endfunction

  logic [7:0] port_mask;
  logic [7:0] analog_mask;
  logic [7:0] digital_in_mask;
  logic [7:0] pin_read;
  logic chg_event;

  always_comb begin
    // oscillator pins join the port only when configured as I/O
    port_mask = {osc_pins_as_io, osc_pins_as_io, 6'h3F};
    analog_mask = analog_pins(analog_config_control_r);
    // comparators own the inputs of bits 3..0 while on
    digital_in_mask = port_mask & ~analog_mask
      & ~{4'h0, {4{comparator_control_r[COMP_IN_BIT]}}};
    // analog pins read as zero; disabled oscillator pins too
    pin_read = pin_sync & digital_in_mask;
  end

  // any change on upper second-port bits
  assign chg_event = |sif.changed[SW-1:PORT_W];

  always_comb begin
    output_latch_reg_a_nxt = output_latch_reg_a_r;
    direction_reg_a_nxt = direction_reg_a_r;
    analog_config_control_nxt = analog_config_control_r;
    comparator_control_nxt = comparator_control_r;
    port_change_flag_nxt = port_change_flag_r;
    port_change_enable_nxt = port_change_enable_r;
    port_change_priority_nxt = port_change_priority_r;
    rdata_nxt = rdata_r;
    if (wr_en) begin
      unique case (addr)
        // write to pin-level register lands in the latch
        OFS_PIN_LEVEL: output_latch_reg_a_nxt = wdata;
        OFS_LATCH: output_latch_reg_a_nxt = wdata;
        OFS_DIRECTION: direction_reg_a_nxt = wdata;
        OFS_ANALOG_CFG: analog_config_control_nxt = wdata[4:0];
        OFS_COMP_CTRL: comparator_control_nxt = wdata[2:0];
        OFS_INT_STATUS: ;
        OFS_INT_MASK: port_change_enable_nxt = wdata[CHG_FLAG_BIT];
        OFS_INT_PRIO: port_change_priority_nxt = wdata[CHG_FLAG_BIT];
      endcase
    end
    if (rd_en) begin
      unique case (addr)
        OFS_PIN_LEVEL: rdata_nxt = pin_read;
        // latched value; disabled bits read zero
        OFS_LATCH: rdata_nxt = output_latch_reg_a_r & port_mask;
        OFS_DIRECTION: rdata_nxt = direction_reg_a_r & port_mask;
        OFS_ANALOG_CFG: rdata_nxt = {3'h0, analog_config_control_r};
        OFS_COMP_CTRL: rdata_nxt = {5'h00, comparator_control_r};
        OFS_INT_STATUS: rdata_nxt = {7'h00, port_change_flag_r};
        OFS_INT_MASK: rdata_nxt = {7'h00, port_change_enable_r};
        OFS_INT_PRIO: rdata_nxt = {7'h00, port_change_priority_r};
      endcase
      // reading status clears the flag
      if (addr == OFS_INT_STATUS) begin
        port_change_flag_nxt = 1'b0;
      end
    end
    // a change in the clearing cycle is kept
    if (chg_event) begin
      port_change_flag_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  always_comb begin
    // drive from the latch where direction is zero
    pin_out_nxt = output_latch_reg_a_r;
    // direction one releases the driver; holds on analog pins too
    pin_oe_n_nxt = direction_reg_a_r;
    // comparator one output takes bit 4
    if (comparator_control_r[COMP1_OUT_BIT]) begin
      pin_out_nxt[TIMER_PIN] = comparator_one_output;
      pin_oe_n_nxt[TIMER_PIN] = 1'b0;
    end
    // comparator two output takes bit 5
    if (comparator_control_r[COMP2_OUT_BIT]) begin
      pin_out_nxt[COMP2_PIN] = comparator_two_output;
      pin_oe_n_nxt[COMP2_PIN] = 1'b0;
    end
    // oscillator owns bits 7..6 unless they are port pins
    if (!osc_pins_as_io) begin
      pin_out_nxt[7:OSC_PIN_LO] = 2'b00;
      pin_oe_n_nxt[7:OSC_PIN_LO] = 2'b11;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      output_latch_reg_a_r <= RST_LATCH;
      direction_reg_a_r <= RST_DIRECTION;
      // analog at reset, bit 4 stays digital input
      analog_config_control_r <= RST_ANALOG_CFG;
      comparator_control_r <= RST_COMP_CTRL;
      port_change_flag_r <= 1'b0;
      port_change_enable_r <= 1'b0;
      port_change_priority_r <= 1'b0;
      rdata_r <= 8'h00;
      pin_out_r <= RST_LATCH;
      pin_oe_n_r <= RST_DIRECTION;
    end else if (ce) begin
      output_latch_reg_a_r <= output_latch_reg_a_nxt;
      direction_reg_a_r <= direction_reg_a_nxt;
      analog_config_control_r <= analog_config_control_nxt;
      comparator_control_r <= comparator_control_nxt;
      port_change_flag_r <= port_change_flag_nxt;
      port_change_enable_r <= port_change_enable_nxt;
      port_change_priority_r <= port_change_priority_nxt;
      rdata_r <= rdata_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = rdata_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  // timer clock taken from the synchronised bit 4 level
  assign timer_clock_input = pin_sync[TIMER_PIN];
  assign second_port_level = chg_sync;
  // enable gates the flag, priority also raises the high-priority output
  assign irq = port_change_flag_r & port_change_enable_r;
  assign irq_high_prio = irq & port_change_priority_r;
endmodule

// ===== logic/input_sync.sv
// two-stage input synchroniser with per-bit change pulse
`timescale 1ns/1ps
module input_sync #(
  parameter int W = 12
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  sync_if.producer sif
);
  logic [W-1:0] meta_r, meta_nxt;
  logic [W-1:0] sync_r, sync_nxt;
  logic [W-1:0] prev_r, prev_nxt;
  logic [2:0] primed_r, primed_nxt;

  always_comb begin
    meta_nxt = sif.raw;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
    primed_nxt = {primed_r[1:0], 1'b1};
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      primed_r <= 3'h0;
    end else if (ce) begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  assign sif.synced = sync_r;
  // no change reported until sync and history stages both hold real pin data,
  // so a pin that idles high does not look like an edge after reset
  assign sif.changed = primed_r[2] ? (sync_r ^ prev_r) : '0;
endmodule

// ===== logic/sync_if.sv
// bundle between the input synchroniser and the port core
`timescale 1ns/1ps
interface sync_if #(parameter int W = 12);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  logic [W-1:0] changed;
  modport producer (input raw, output synced, output changed);
  modport consumer (output raw, input synced, input changed);
endinterface

// ===== verif/gpio_port_sva.sv
// concurrent checks on the port pins, bus and change interrupt
`timescale 1ns/1ps
module gpio_port_sva
  import gpio_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [gpio_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic [gpio_pkg::PORT_W-1:0] pin_in,
  input wire logic [gpio_pkg::PORT_W-1:0] pin_out,
  input wire logic [gpio_pkg::PORT_W-1:0] pin_oe_n,
  input wire logic [gpio_pkg::CHG_W-1:0] second_port_in,
  input wire logic osc_pins_as_io,
  input wire logic comparator_one_output,
  input wire logic comparator_two_output,
  input wire logic timer_clock_input,
  input wire logic [gpio_pkg::CHG_W-1:0] second_port_level,
  input wire logic irq,
  input wire logic irq_high_prio
);
  logic en_r;
  logic pr_r;
  // shadow of enable and priority, so the gating can be checked from the ports
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      en_r <= 1'b0;
      pr_r <= 1'b0;
    end else if (ce && wr_en && addr == OFS_INT_MASK) begin
      en_r <= wdata[0];
    end else if (ce && wr_en && addr == OFS_INT_PRIO) begin
      pr_r <= wdata[0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_dir_to_oe: assert property (wr_en && ce && addr == OFS_DIRECTION ##1 ce |=>
    pin_oe_n[3:0] == $past(wdata[3:0], 2)) else $error("pin enable mismatch");
  a_latch_to_pin: assert property (wr_en && ce && addr <= OFS_LATCH ##1 ce |=>
    pin_out[3:0] == $past(wdata[3:0], 2)) else $error("pin drive mismatch");
  a_osc_pins_off: assert property (!osc_pins_as_io && !$past(osc_pins_as_io) && $past(ce) |->
    pin_oe_n[7:6] == 2'h3) else $error("oscillator pins driven");
  a_comp_owns: assert property (
    wr_en && ce && addr == OFS_COMP_CTRL && wdata[1] ##1 ce |=> !pin_oe_n[4])
    else $error("comparator output not on pin");
  a_input_sync: assert property (
    $past(reset_n) && $past(reset_n, 2) && $past(ce) && $past(ce, 2) |->
    {timer_clock_input, second_port_level} == $past({pin_in[4], second_port_in}, 2))
    else $error("synchroniser latency wrong");
  // the first level taken after reset is not a change
  a_change_irq: assert property ($changed(second_port_level) && en_r && ce && !wr_en
    && $past(reset_n, 3) |=> irq) else $error("change did not raise irq");
  a_read_clears: assert property (
    rd_en && ce && $past(ce) && addr == OFS_INT_STATUS && !$changed(second_port_level)
    |=> !irq)
    else $error("status read left irq high");
  a_prio_gate: assert property (irq_high_prio == (irq && pr_r))
    else $error("priority output wrong");
  c_high_prio: cover property (irq_high_prio);
  c_status_read: cover property (irq ##1 rd_en && addr == OFS_INT_STATUS);
  c_comp_drive: cover property (!pin_oe_n[4] && !pin_oe_n[5]);
endmodule
bind gpio_port gpio_port_sva i_gpio_port_sva (.*);

// ===== verif/gpio_port_test.sv
// self-checking bench for the bidirectional port and its change interrupt
`timescale 1ns/1ps
module gpio_port_test;
  import gpio_pkg::*;
  logic mclk, reset_n, ce, wr_en, rd_en, osc_pins_as_io, timer_clock_input;
  logic comparator_one_output, comparator_two_output, irq, irq_high_prio;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, pin_in, pin_out, pin_oe_n, ext_val, ext_drv;
  logic [3:0] second_port_in, second_port_level;
  int n_mismatch, total_checks;
  gpio_port i_gpio_port (.*);
  pin_model i_pin_model (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask
  // the wait after a write covers the pin register and the two sync stages
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic rd(input string what, input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    chk(what, rdata, exp);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    ce <= 1'b1;
    osc_pins_as_io <= 1'b1;
    {wr_en, rd_en, addr, wdata, second_port_in} <= '0;
    {comparator_one_output, comparator_two_output} <= 2'h0;
    ext_val <= 8'hFF;
    ext_drv <= 8'hFF;
    do_reset();
    chk("pin_oe_n", pin_oe_n, 8'hFF);
    rd("latch", OFS_LATCH, 8'h00);
    rd("direction", OFS_DIRECTION, 8'hFF);
    rd("analog", OFS_ANALOG_CFG, 8'h1F);
    rd("comparator", OFS_COMP_CTRL, 8'h00);
    rd("pins", OFS_PIN_LEVEL, 8'hD0);
    wr(OFS_ANALOG_CFG, 8'h00);
    ext_val <= 8'hA5;
    wr(OFS_COMP_CTRL, 8'h01);
    rd("pins", OFS_PIN_LEVEL, 8'hA0);
    // comparators off and pins digital before driving
    wr(OFS_COMP_CTRL, 8'h00);
    rd("pins", OFS_PIN_LEVEL, 8'hA5);
    ext_drv <= 8'h00;
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_PIN_LEVEL, 8'hC3);
    chk("pin_oe_n", pin_oe_n, 8'h00);
    chk("pin_out", pin_out, 8'hC3);
    rd("latch", OFS_LATCH, 8'hC3);
    rd("pins", OFS_PIN_LEVEL, 8'hC3);
    ext_val <= 8'h00;
    ext_drv <= 8'hFF;
    wr(OFS_DIRECTION, 8'hFF);
    chk("pin_oe_n", pin_oe_n, 8'hFF);
    rd("pins", OFS_PIN_LEVEL, 8'h00);
    rd("latch", OFS_LATCH, 8'hC3);
    comparator_one_output <= 1'b1;
    comparator_two_output <= 1'b1;
    wr(OFS_COMP_CTRL, 8'h06);
    chk("pin_oe_n", pin_oe_n, 8'hCF);
    chk("pin_out", pin_out, 8'hF3);
    chk("timer", {7'h00, timer_clock_input}, 8'h01);
    wr(OFS_COMP_CTRL, 8'h00);
    osc_pins_as_io <= 1'b0;
    ext_val <= 8'hFF;
    do_reset();
    wr(OFS_DIRECTION, 8'h00);
    wr(OFS_LATCH, 8'hFF);
    chk("pin_oe_n", pin_oe_n, 8'hC0);
    rd("latch", OFS_LATCH, 8'h3F);
    wr(OFS_DIRECTION, 8'hFF);
    rd("direction", OFS_DIRECTION, 8'h3F);
    wr(OFS_ANALOG_CFG, 8'h00);
    rd("pins", OFS_PIN_LEVEL, 8'h3F);
    ce <= 1'b0;
    wr(OFS_LATCH, 8'h00);
    ce <= 1'b1;
    rd("latch", OFS_LATCH, 8'h3F);
    wr(OFS_INT_MASK, 8'h01);
    wr(OFS_INT_STATUS, 8'h01);
    rd("status", OFS_INT_STATUS, 8'h00);
    second_port_in <= 4'h4;
    repeat (4) @(posedge mclk);
    chk("irq", {6'h00, irq, irq_high_prio}, 8'h02);
    chk("level", {4'h0, second_port_level}, 8'h04);
    wr(OFS_INT_PRIO, 8'h01);
    chk("irq", {6'h00, irq, irq_high_prio}, 8'h03);
    rd("status", OFS_INT_STATUS, 8'h01);
    chk("irq", {6'h00, irq, irq_high_prio}, 8'h00);
    wr(OFS_INT_MASK, 8'h00);
    second_port_in <= 4'h5;
    repeat (4) @(posedge mclk);
    chk("irq", {6'h00, irq, irq_high_prio}, 8'h00);
    rd("status", OFS_INT_STATUS, 8'h01);
    rd("status", OFS_INT_STATUS, 8'h00);
    stop_test();
  end
endmodule

// ===== verif/pin_model.sv
// pin-side model: resolves each port pin from the design driver and an outside driver
`timescale 1ns/1ps
module pin_model (
  input wire logic mclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin_in
);
  // an undriven pin wanders so a stale level never reads back by luck
  logic [7:0] flt_r = 8'h55;
  always @(posedge mclk) flt_r <= ~flt_r;
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_drv & ext_val) | (~ext_drv & flt_r)));
endmodule
